// ---- logic/ifd_decoder.sv ----
//////////////////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "ifd_regs.svh"
module ifd_decoder
  import ifd_pkg::*;
#(
  parameter int LW = 16,
  parameter int PW = 18,
  parameter int TW = 16
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Feedback pins: A or F or clockwise, B or D or counterclockwise, index, commutation
  input  wire logic        chA,
  input  wire logic        chB,
  input  wire logic        chZ,
  input  wire logic        chU,
  input  wire logic        chV,
  input  wire logic        chW,
  // Line receiver open-wire indications
  input  wire logic        brkA,
  input  wire logic        brkB,
  input  wire logic        brkZ,
  // Termination and supply controls
  output logic             termPulseEn,
  output logic             termIndexEn,
  output logic             supply5vEn,
  output logic             supply8vEn,
  output logic             supply15vEn,
  // Interrupt
  output logic             irq
);
  //////////////////////////////////////////////////////////////////////////////////////////
  logic [`IFD_CFG_BITS-1:0] config_q;
  logic [LW-1:0]            linesPerRev;
  logic [PW-1:0]            posInRev;
  logic [TW-1:0]            turns;
  logic [PW-1:0]            indexPos;
  logic [`IFD_ST_BITS-1:0]  status;
  logic [`IFD_ST_BITS-1:0]  mask;
  logic [8:0]               pinSync;
  logic                     sA, sB, sZ, sU, sV, sW, sBrkA, sBrkB, sBrkZ;
  logic                     pA, pB, pZ;
  logic [3:0]               fbType;
  logic [1:0]               termSel;
  logic [1:0]               errLvl;
  logic [1:0]               supplySel;
  ifd_format_t              fmt;
  logic                     isCommutated;
  logic                     isQuadFamilyTerm;
  logic                     stepUp;
  logic                     stepDown;
  logic                     quadIllegal;
  logic                     zRise;
  logic [PW-1:0]            modulus;
  logic [PW-1:0]            next_pos;
  logic                     wrapUp;
  logic                     wrapDown;
  logic                     wireBrkEvt;
  logic                     phaseEvt;
  logic [`IFD_ST_BITS-1:0]  events;
  logic                     apbWrite;
  logic                     apbSetup;
  logic                     addrHit;

  assign fbType    = config_q[`IFD_CFG_TYPE];
  assign supplySel = config_q[`IFD_CFG_SUPPLY];
  assign termSel   = config_q[`IFD_CFG_TERM];
  assign errLvl    = config_q[`IFD_CFG_ERRLVL];

  //////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  ifd_sync #(.W(9)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pinIn    ({brkZ, brkB, brkA, chW, chV, chU, chZ, chB, chA}),
    .syncOut  (pinSync)
  );
  assign {sBrkZ, sBrkB, sBrkA, sW, sV, sU, sZ, sB, sA} = pinSync;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pA <= 1'b0;
      pB <= 1'b0;
      pZ <= 1'b0;
    end else begin
      pA <= sA;
      pB <= sB;
      pZ <= sZ;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Format decode
  always_comb begin
    fmt              = IFD_FMT_NONE;
    isCommutated     = 1'b0;
    isQuadFamilyTerm = 1'b0;
    case (fbType)
      IFD_QUAD_PLAIN_TYPE: begin
        fmt              = IFD_FMT_QUAD;
        isQuadFamilyTerm = 1'b1;
      end
      IFD_QUAD_COMMUTATED_TYPE: begin
        fmt              = IFD_FMT_QUAD;
        isCommutated     = 1'b1;
        isQuadFamilyTerm = 1'b1;
      end
      IFD_SINCOS_INCREMENTAL_TYPE: begin
        fmt = IFD_FMT_QUAD;
      end
      IFD_FREQ_DIR_PLAIN_TYPE: begin
        fmt              = IFD_FMT_FREQDIR;
        isQuadFamilyTerm = 1'b1;
      end
      IFD_FWD_REV_PLAIN_TYPE: begin
        fmt              = IFD_FMT_FWDREV;
        isQuadFamilyTerm = 1'b1;
      end
      IFD_FREQ_DIR_COMMUTATED_TYPE: begin
        fmt              = IFD_FMT_FREQDIR;
        isCommutated     = 1'b1;
        isQuadFamilyTerm = 1'b1;
      end
      IFD_FWD_REV_COMMUTATED_TYPE: begin
        fmt              = IFD_FMT_FWDREV;
        isCommutated     = 1'b1;
        isQuadFamilyTerm = 1'b1;
      end
      default: begin
        fmt = IFD_FMT_NONE;
      end
    endcase
  end

  // Sine and cosine arrive squared by the comparators, so they decode as quadrature
  always_comb begin
    stepUp      = 1'b0;
    stepDown    = 1'b0;
    quadIllegal = 1'b0;
    case (fmt)
      IFD_FMT_QUAD: begin
        quadIllegal = (sA ^ pA) & (sB ^ pB);
        stepUp      = ((sA ^ pA) ^ (sB ^ pB)) & ~(pA ^ sB);
        stepDown    = ((sA ^ pA) ^ (sB ^ pB)) & (pA ^ sB);
      end
      IFD_FMT_FREQDIR: begin
        stepUp   = sA & ~pA & ~sB;
        stepDown = sA & ~pA & sB;
      end
      IFD_FMT_FWDREV: begin
        stepUp   = sA & ~pA & ~(sB & ~pB);
        stepDown = sB & ~pB & ~(sA & ~pA);
      end
      default: begin
        stepUp   = 1'b0;
        stepDown = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Position within the revolution
  // Quadrature gives four counts per line; pulse formats count both pulses of a line pair
  assign modulus = (fmt == IFD_FMT_QUAD) ? PW'({linesPerRev, 2'b00})
                                         : PW'({linesPerRev, 1'b0});
  assign wrapUp   = stepUp & (posInRev == modulus - PW'(1));
  assign wrapDown = stepDown & (posInRev == '0);

  always_comb begin
    next_pos = posInRev;
    if (modulus == '0) begin
      next_pos = '0;
    end else if (wrapUp) begin
      next_pos = '0;
    end else if (stepUp) begin
      next_pos = posInRev + PW'(1);
    end else if (wrapDown) begin
      next_pos = modulus - PW'(1);
    end else if (stepDown) begin
      next_pos = posInRev - PW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      posInRev <= '0;
      turns    <= '0;
    end else begin
      posInRev <= next_pos;
      if (modulus != '0 && wrapUp) begin
        turns <= turns + TW'(1);
      end else if (modulus != '0 && wrapDown) begin
        turns <= turns - TW'(1);
      end
    end
  end

  assign zRise = sZ & ~pZ & (fmt != IFD_FMT_NONE);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      indexPos <= '0;
    end else if (zRise) begin
      indexPos <= posInRev;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Termination and supply
  always_comb begin
    termPulseEn = 1'b0;
    termIndexEn = 1'b0;
    if (isQuadFamilyTerm) begin
      case (termSel)
        `IFD_TERM_PULSE: begin
          termPulseEn = 1'b1;
        end
        `IFD_TERM_ALL: begin
          termPulseEn = 1'b1;
          termIndexEn = 1'b1;
        end
        default: begin
          termPulseEn = 1'b0;
        end
      endcase
    end
  end

  // An unused supply code leaves every rail off rather than guess a voltage
  assign supply5vEn  = (supplySel == `IFD_SUP_5V);
  assign supply8vEn  = (supplySel == `IFD_SUP_8V);
  assign supply15vEn = (supplySel == `IFD_SUP_15V);

  //////////////////////////////////////////////////////////////////////////////////////////
  // Fault detection; an open line can only be seen across its terminating resistor
  assign wireBrkEvt = (errLvl == `IFD_ERR_WIRE || errLvl == `IFD_ERR_BOTH)
                      & (fmt != IFD_FMT_NONE)
                      & ((termPulseEn & (sBrkA | sBrkB))
                         | (termIndexEn & sBrkZ));
  assign phaseEvt   = (errLvl == `IFD_ERR_PHASE || errLvl == `IFD_ERR_BOTH)
                      & isCommutated
                      & (({sU, sV, sW} == `IFD_UVW_ALLLOW)
                         | ({sU, sV, sW} == `IFD_UVW_ALLHIGH)
                         | quadIllegal);
  assign events = {zRise, phaseEvt, wireBrkEvt};

  //////////////////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  assign pready   = 1'b1;
  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pwrite;
  assign addrHit  = (paddr[1:0] == 2'b00) && (paddr <= `IFD_OFS_INPUTS);
  assign pslverr  = psel & penable & ~addrHit;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      config_q    <= `IFD_RST_CONFIG;
      linesPerRev <= `IFD_RST_LINES;
      mask        <= `IFD_RST_MASK;
    end else if (apbWrite) begin
      case (paddr)
        `IFD_OFS_CONFIG: config_q    <= pwdata[`IFD_CFG_BITS-1:0];
        `IFD_OFS_LINES:  linesPerRev <= pwdata[LW-1:0];
        `IFD_OFS_MASK:   mask        <= pwdata[`IFD_ST_BITS-1:0];
        default:         mask        <= mask;
      endcase
    end
  end

  // A fault in the same cycle as its clear stays recorded
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      status <= '0;
    end else if (apbWrite && paddr == `IFD_OFS_STATUS) begin
      status <= (status & ~pwdata[`IFD_ST_BITS-1:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= '0;
    end else if (apbSetup && !pwrite) begin
      case (paddr)
        `IFD_OFS_CONFIG:   prdata <= 32'(config_q);
        `IFD_OFS_LINES:    prdata <= 32'(linesPerRev);
        `IFD_OFS_POSITION: prdata <= 32'(posInRev);
        `IFD_OFS_TURNS:    prdata <= 32'(turns);
        `IFD_OFS_INDEXPOS: prdata <= 32'(indexPos);
        `IFD_OFS_STATUS:   prdata <= 32'(status);
        `IFD_OFS_MASK:     prdata <= 32'(mask);
        `IFD_OFS_INPUTS:   prdata <= 32'({sBrkZ, sBrkB, sBrkA, sW, sV, sU, sZ, sB, sA});
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign irq = |(status & mask);

  //////////////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_quad_count_up: assert property (@(posedge core_clk) disable iff (!rstn)
    (fmt == IFD_FMT_QUAD && stepUp && !wrapUp && modulus != '0)
      |=> posInRev == $past(posInRev) + PW'(1))
    else $error("quadrature step up did not advance position");

  a_pulse_count_down: assert property (@(posedge core_clk) disable iff (!rstn)
    (fmt == IFD_FMT_FREQDIR && sA && !pA && sB && posInRev != '0 && modulus != '0)
      |=> posInRev == $past(posInRev) - PW'(1))
    else $error("direction pulse did not count down");

  a_pulse_modulus: assert property (@(posedge core_clk) disable iff (!rstn)
    (fmt == IFD_FMT_FWDREV) |-> modulus == PW'({linesPerRev, 1'b0}))
    else $error("pulse format modulus not twice lines");

  a_term_decode: assert property (@(posedge core_clk) disable iff (!rstn)
    (isQuadFamilyTerm && termSel == `IFD_TERM_PULSE) |-> termPulseEn && !termIndexEn)
    else $error("termination code 1 decoded wrongly");

  a_sincos_noterm: assert property (@(posedge core_clk) disable iff (!rstn)
    (fbType == IFD_SINCOS_INCREMENTAL_TYPE) |-> !termPulseEn && !termIndexEn)
    else $error("termination driven for sine cosine type");

  a_level0_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
    (errLvl == `IFD_ERR_NONE && !(apbWrite && paddr == `IFD_OFS_CONFIG))
      |=> $stable(status[`IFD_ST_PHASE:`IFD_ST_WIREBRK]) || $fell(status[`IFD_ST_WIREBRK])
          || $fell(status[`IFD_ST_PHASE]))
    else $error("fault flagged with detection disabled");

  a_wire_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    (errLvl == `IFD_ERR_WIRE && fmt != IFD_FMT_NONE && termPulseEn && sBrkA)
      |=> status[`IFD_ST_WIREBRK])
    else $error("broken pulse wire not flagged");

  a_phase_only: assert property (@(posedge core_clk) disable iff (!rstn)
    (errLvl == `IFD_ERR_PHASE) |-> !wireBrkEvt)
    else $error("wire break checked at phase-only level");

  a_phase_commut: assert property (@(posedge core_clk) disable iff (!rstn)
    (phaseEvt) |-> isCommutated && errLvl[1])
    else $error("phase check on uncommutated type");

  a_term_needed: assert property (@(posedge core_clk) disable iff (!rstn)
    (wireBrkEvt) |-> termPulseEn)
    else $error("wire break seen without termination");

  a_supply_decode: assert property (@(posedge core_clk) disable iff (!rstn)
    $onehot0({supply5vEn, supply8vEn, supply15vEn})
      && (supplySel == `IFD_SUP_8V) == supply8vEn)
    else $error("supply select decoded wrongly");

  a_fault_sticky: assert property (@(posedge core_clk) disable iff (!rstn)
    (status[`IFD_ST_WIREBRK] && !(apbWrite && paddr == `IFD_OFS_STATUS))
      |=> status[`IFD_ST_WIREBRK])
    else $error("wire break flag dropped without a clear");
endmodule // ifd_decoder

// ---- logic/ifd_pkg.sv ----
package ifd_pkg;
  typedef enum logic [3:0] {
    IFD_QUAD_PLAIN_TYPE         = 4'h0,
    IFD_FREQ_DIR_PLAIN_TYPE     = 4'h1,
    IFD_FWD_REV_PLAIN_TYPE      = 4'h2,
    IFD_QUAD_COMMUTATED_TYPE    = 4'h3,
    IFD_FREQ_DIR_COMMUTATED_TYPE = 4'h4,
    IFD_FWD_REV_COMMUTATED_TYPE = 4'h5,
    IFD_SINCOS_INCREMENTAL_TYPE = 4'h6
  } ifd_fb_type_t;

  typedef enum logic [1:0] {
    IFD_FMT_QUAD,
    IFD_FMT_FREQDIR,
    IFD_FMT_FWDREV,
    IFD_FMT_NONE
  } ifd_format_t;
endpackage

// ---- logic/ifd_regs.svh ----
`ifndef IFD_REGS_SVH
`define IFD_REGS_SVH
// Register byte offsets
`define IFD_OFS_CONFIG   8'h00
`define IFD_OFS_LINES    8'h04
`define IFD_OFS_POSITION 8'h08
`define IFD_OFS_TURNS    8'h0c
`define IFD_OFS_INDEXPOS 8'h10
`define IFD_OFS_STATUS   8'h14
`define IFD_OFS_MASK     8'h18
`define IFD_OFS_INPUTS   8'h1c
// Configuration fields
`define IFD_CFG_TYPE     3:0
`define IFD_CFG_SUPPLY   5:4
`define IFD_CFG_TERM     7:6
`define IFD_CFG_ERRLVL   9:8
`define IFD_CFG_BITS     10
// Status fields
`define IFD_ST_WIREBRK   0
`define IFD_ST_PHASE     1
`define IFD_ST_INDEX     2
`define IFD_ST_BITS      3
// Reset values
`define IFD_RST_CONFIG   10'h000
`define IFD_RST_LINES    16'h0400
`define IFD_RST_MASK     3'h0
// Codes of the selectors
`define IFD_TERM_OFF     2'h0
`define IFD_TERM_PULSE   2'h1
`define IFD_TERM_ALL     2'h2
`define IFD_SUP_5V       2'h0
`define IFD_SUP_8V       2'h1
`define IFD_SUP_15V      2'h2
`define IFD_ERR_NONE     2'h0
`define IFD_ERR_WIRE     2'h1
`define IFD_ERR_PHASE    2'h2
`define IFD_ERR_BOTH     2'h3
`define IFD_UVW_ALLLOW   3'h0
`define IFD_UVW_ALLHIGH  3'h7
`endif

// ---- logic/ifd_sync.sv ----
`timescale 1ns/1ps
// Three-stage pin synchroniser; a change is accepted once stages two and three agree
module ifd_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Bitwise agreement filters a single metastable resolution glitch
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      syncOut <= '0;
    end else begin
      syncOut <= (stage2 & stage3) | (syncOut & (stage2 ^ stage3));
    end
  end
endmodule // ifd_sync

// ---- tb/ifd_encoder_model.sv ----
`timescale 1ns/1ps
module ifd_encoder_model (
  // Clock
  input  wire logic core_clk,
  // Encoder pins
  output logic      chA,
  output logic      chB,
  output logic      chZ,
  output logic      chU,
  output logic      chV,
  output logic      chW,
  // Receiver open-wire flags
  output logic      brkA,
  output logic      brkB,
  output logic      brkZ
);
  // Levels outlast the decoder's pin filter, so no edge is lost
  localparam int         HOLD    = 7;
  localparam logic [7:0] FWD_SEQ = 8'hb4;
  localparam logic [7:0] REV_SEQ = 8'h78;

  initial begin
    {chA, chB, chZ} = 3'h0;
    // Commutation idles at a legal pattern, so commutated types see no phase fault
    {chU, chV, chW} = 3'h1;
    {brkZ, brkB, brkA} = 3'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One full quadrature cycle; going forward A leads B
  task automatic quad_cycle(input logic fwd);
    logic [7:0] s;
    s = fwd ? FWD_SEQ : REV_SEQ;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      {chA, chB} <= s[7-2*i -: 2];
      repeat (HOLD) @(posedge core_clk);
    end
  endtask

  // Pulse on the first pin (F or clockwise) or on the second (counterclockwise)
  task automatic pulse(input logic onB);
    for (int lv = 1; lv >= 0; lv--) begin
      @(posedge core_clk);
      if (onB)
        chB <= lv[0];
      else
        chA <= lv[0];
      repeat (HOLD) @(posedge core_clk);
    end
  endtask

  // Direction level on the second pin, changed only while no pulse runs
  task automatic set_dir(input logic d);
    @(posedge core_clk);
    chB <= d;
    repeat (HOLD) @(posedge core_clk);
  endtask

  // Index mark, high long enough to pass the decoder's pin filter
  task automatic index_pulse;
    @(posedge core_clk);
    chZ <= 1'b1;
    repeat (HOLD) @(posedge core_clk);
    chZ <= 1'b0;
    repeat (HOLD) @(posedge core_clk);
  endtask

  task automatic set_faults(input logic [2:0] brk, input logic [2:0] uvw);
    @(posedge core_clk);
    {brkZ, brkB, brkA} <= brk;
    {chU, chV, chW} <= uvw;
  endtask
endmodule // ifd_encoder_model

// ---- tb/test_incremental_feedback_decoder.sv ----
`timescale 1ns/1ps
`include "ifd_regs.svh"
`define CHK(what, expv, got) \
  begin \
    samplesChecked++; \
    if ((got) !== (expv)) begin \
      failures++; \
      $display("BAD %s expected %0h seen %0h", what, expv, got); \
    end \
  end
module test_incremental_feedback_decoder
  import ifd_pkg::*;
();
  // Clock, reset and bus
  logic        core_clk = 1'b0;
  logic        rstn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, r;
  // Pins and controls
  logic        chA, chB, chZ, chU, chV, chW, brkA, brkB, brkZ, irq;
  logic        termPulseEn, termIndexEn, supply5vEn, supply8vEn, supply15vEn;
  int          failures = 0;
  int          samplesChecked = 0;
  localparam logic [3:0] TYPES [7] = '{4'h0, 4'h3, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};

  always #12.5 core_clk = ~core_clk;

  ifd_decoder u_dut (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .chA, .chB, .chZ, .chU, .chV, .chW, .brkA, .brkB, .brkZ,
    .termPulseEn, .termIndexEn, .supply5vEn, .supply8vEn, .supply15vEn, .irq);
  ifd_encoder_model u_enc (.core_clk, .chA, .chB, .chZ, .chU, .chV, .chW, .brkA, .brkB,
    .brkZ);

  //////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rdata, output logic err);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        er;
    apb(1'b1, a, d, r, er);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic er;
    apb(1'b0, a, 32'h0, r, er);
  endtask

  // Outputs decoded from the configuration are sampled half a cycle after the write
  task automatic cfg(input logic [3:0] ty, input logic [1:0] sup, input logic [1:0] term,
                     input logic [1:0] lvl);
    wr(`IFD_OFS_CONFIG, {22'h0, lvl, term, sup, ty});
    @(negedge core_clk);
  endtask

  task automatic count_case(input logic [3:0] ty, input int expDelta);
    logic [31:0] p0, p1;
    logic        fd;
    int          m;
    cfg(ty, 2'h0, 2'h2, 2'h0);
    rd(`IFD_OFS_POSITION, p0);
    fd = (ty == 4'h1 || ty == 4'h4);
    if (fd || ty == 4'h2 || ty == 4'h5) begin
      m = 128;
      u_enc.pulse(1'b0);
      u_enc.pulse(1'b0);
      if (fd) u_enc.set_dir(1'b1);
      u_enc.pulse(!fd);
      if (fd) u_enc.set_dir(1'b0);
    end else begin
      m = 256;
      u_enc.quad_cycle(1'b1);
      u_enc.quad_cycle(1'b1);
      u_enc.quad_cycle(1'b0);
    end
    repeat (8) @(posedge core_clk);
    rd(`IFD_OFS_POSITION, p1);
    `CHK("position step", expDelta, (p1[17:0] + m - p0[17:0]) % m)
  endtask

  task automatic fault_case(input logic [3:0] ty, input logic [1:0] lvl,
                            input logic [1:0] term, input logic [2:0] brk,
                            input logic [2:0] uvw, input logic [1:0] expFlags);
    logic [31:0] s;
    cfg(ty, 2'h0, term, lvl);
    u_enc.set_faults(brk, uvw);
    repeat (10) @(posedge core_clk);
    rd(`IFD_OFS_STATUS, s);
    `CHK("fault flags", expFlags, s[1:0])
    rd(`IFD_OFS_INPUTS, s);
    `CHK("input pins", {brk, uvw[0], uvw[1], uvw[2], 3'h0}, s[8:0])
    u_enc.set_faults(3'h0, 3'h1);
    repeat (10) @(posedge core_clk);
    rd(`IFD_OFS_STATUS, s);
    `CHK("sticky flags", expFlags, s[1:0])
    wr(`IFD_OFS_STATUS, 32'h7);
    rd(`IFD_OFS_STATUS, s);
    `CHK("cleared flags", 2'h0, s[1:0])
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, psel, penable} = 3'h0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    `CHK("reset outputs", 4'h8, {supply5vEn, termPulseEn, termIndexEn, irq})
    rd(`IFD_OFS_CONFIG, q);
    `CHK("config reset", 32'h0, q)
    rd(`IFD_OFS_LINES, q);
    `CHK("lines reset", 32'h400, q)
    rd(`IFD_OFS_MASK, q);
    `CHK("mask reset", 32'h0, q)
    wr(`IFD_OFS_CONFIG, 32'hffffffff);
    rd(`IFD_OFS_CONFIG, q);
    `CHK("config width", 32'h3ff, q)
    apb(1'b0, 8'h20, 32'h0, q, e);
    `CHK("unmapped error", 1'b1, e)
    `CHK("unmapped data", 32'h0, q)
    $display("test registers done");

    // Supplies are stepped with termination code 0; the decoder never ties termination to the supply
    for (int s = 0; s < 4; s++) begin
      cfg(4'h0, s[1:0], 2'h0, 2'h0);
      `CHK("supply", (s < 3) ? (3'h1 << s) : 3'h0, {supply15vEn, supply8vEn, supply5vEn})
    end
    for (int k = 0; k < 7; k++)
      for (int t = 0; t < 4; t++) begin
        cfg(TYPES[k], 2'h0, t[1:0], 2'h0);
        `CHK("pulse term", TYPES[k] != 4'h6 && (t == 1 || t == 2), termPulseEn)
        `CHK("index term", TYPES[k] != 4'h6 && t == 2, termIndexEn)
      end
    $display("test selectors done");

    // 64 lines: 64 quadrature lines, or 128 pulses per revolution
    wr(`IFD_OFS_LINES, 32'h40);
    for (int k = 0; k < 7; k++)
      count_case(TYPES[k], (k < 2 || k == 6) ? 4 : 1);
    count_case(4'h7, 0);
    // Net count so far is 4+4+1+1+1+1+4 = 16
    cfg(4'h0, 2'h0, 2'h2, 2'h0);
    u_enc.index_pulse();
    rd(`IFD_OFS_INDEXPOS, q);
    `CHK("index position", 18'h10, q[17:0])
    rd(`IFD_OFS_STATUS, q);
    `CHK("index seen", 1'b1, q[2])
    wr(`IFD_OFS_STATUS, 32'h4);
    // Zero lines parks the position at 0, then one line wraps every four counts
    wr(`IFD_OFS_LINES, 32'h0);
    wr(`IFD_OFS_LINES, 32'h1);
    rd(`IFD_OFS_TURNS, q);
    u_enc.quad_cycle(1'b1);
    repeat (8) @(posedge core_clk);
    rd(`IFD_OFS_TURNS, r);
    `CHK("one turn", q[15:0] + 16'h1, r[15:0])
    rd(`IFD_OFS_POSITION, r);
    `CHK("wrapped position", 18'h0, r[17:0])
    $display("test counting done");

    fault_case(4'h0, 2'h1, 2'h2, 3'h1, 3'h1, 2'h1);
    fault_case(4'h0, 2'h1, 2'h2, 3'h4, 3'h1, 2'h1);
    fault_case(4'h0, 2'h0, 2'h2, 3'h7, 3'h0, 2'h0);
    fault_case(4'h0, 2'h1, 2'h0, 3'h7, 3'h1, 2'h0);
    fault_case(4'h0, 2'h1, 2'h1, 3'h4, 3'h1, 2'h0);
    fault_case(4'h3, 2'h2, 2'h2, 3'h1, 3'h0, 2'h2);
    fault_case(4'h0, 2'h2, 2'h2, 3'h0, 3'h0, 2'h0);
    fault_case(4'h3, 2'h3, 2'h2, 3'h2, 3'h7, 2'h3);
    fault_case(4'h2, 2'h1, 2'h2, 3'h2, 3'h1, 2'h1);
    fault_case(4'h4, 2'h3, 2'h1, 3'h1, 3'h0, 2'h3);
    fault_case(4'h1, 2'h3, 2'h2, 3'h1, 3'h0, 2'h1);
    fault_case(4'h5, 2'h2, 2'h2, 3'h0, 3'h7, 2'h2);
    fault_case(4'h6, 2'h1, 2'h2, 3'h1, 3'h1, 2'h0);
    $display("test faults done");

    cfg(4'h3, 2'h0, 2'h2, 2'h3);
    u_enc.set_faults(3'h1, 3'h0);
    repeat (10) @(posedge core_clk);
    u_enc.set_faults(3'h0, 3'h1);
    repeat (10) @(posedge core_clk);
    `CHK("irq masked", 1'b0, irq)
    wr(`IFD_OFS_STATUS, 32'h2);
    rd(`IFD_OFS_STATUS, q);
    `CHK("one bit cleared", 2'h1, q[1:0])
    wr(`IFD_OFS_MASK, 32'h2);
    @(negedge core_clk);
    `CHK("irq other mask", 1'b0, irq)
    wr(`IFD_OFS_MASK, 32'h1);
    @(negedge core_clk);
    `CHK("irq raised", 1'b1, irq)
    wr(`IFD_OFS_STATUS, 32'h1);
    @(negedge core_clk);
    `CHK("irq cleared", 1'b0, irq)
    $display("test interrupt done");
    results();
  end

  // The whole sequence needs under 8000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    results();
  end
endmodule // test_incremental_feedback_decoder
